// [sesr_ctrl_model.sv]
// Bus controller model that answers service requests with serial polls
`timescale 1ns/1ps
module sesr_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       srq_i,
  input  wire logic       en_i,
  input  wire logic [3:0] delay_i,
  input  wire logic [7:0] poll_byte_i,
  output logic            serial_poll_o,
  output logic [7:0]      seen_o,
  output int              polls_o
);
  ////////////////////////////////////////
  // Poll after a programmable wait of delay_i cycles, so prompt or slow hosts can be modelled
  initial begin
    serial_poll_o = 1'b0;
    seen_o = 8'h00;
    polls_o = 0;
  end
  always begin
    @(negedge clk_i);
    if (en_i && srq_i) begin
      repeat (delay_i) @(negedge clk_i);
      serial_poll_o = 1'b1;
      @(negedge clk_i);
      serial_poll_o = 1'b0;
      seen_o = poll_byte_i; // Captured poll byte is settled here
      polls_o++;
    end
  end
endmodule // sesr_ctrl_model

// [sesr_pkg.sv]
// Package with constants and types for the status event and service request block
package sesr_pkg;

  // Standard event bit positions
  localparam int unsigned SE_PON_BIT = 7;
  localparam int unsigned SE_CME_BIT = 5;
  localparam int unsigned SE_EXE_BIT = 4;
  localparam int unsigned SE_QYE_BIT = 2;
  localparam int unsigned SE_OPC_BIT = 0;

  // Status byte bit positions
  localparam int unsigned SB_OSB_BIT = 7;
  localparam int unsigned SB_RQS_BIT = 6;
  localparam int unsigned SB_ESB_BIT = 5;
  localparam int unsigned SB_MAV_BIT = 4;

  // Reset values of the event latches and mask registers
  localparam logic [7:0] SESR_LATCH_RESET = 8'h00;
  localparam logic [7:0] SESR_MASK_RESET  = 8'h00;

  // Register query and write commands
  typedef enum logic [2:0] {
    SESR_CMD_NONE      = 3'h0,
    SESR_CMD_STD_MASK  = 3'h1,
    SESR_CMD_STD_LATCH = 3'h2,
    SESR_CMD_OP_MASK   = 3'h3,
    SESR_CMD_OP_LATCH  = 3'h4,
    SESR_CMD_OP_COND   = 3'h5,
    SESR_CMD_SUMMARY   = 3'h6,
    SESR_CMD_SRV_MASK  = 3'h7
  } sesr_cmd_t;

  // One command from the parser
  typedef struct packed {
    logic      valid;
    logic      write;
    sesr_cmd_t reg_sel;
    logic [7:0] wdata;
  } sesr_req_t;

  // Operation event sources, one-cycle pulses
  typedef struct packed {
    logic comm_lost;
    logic cal_bad;
    logic fresh_sample_flag;
    logic loop1_slope_finished;
    logic loop2_slope_finished;
    logic input_a_overrange;
    logic input_b_overrange;
  } sesr_op_src_t;

  // Standard event sources, one-cycle pulses
  typedef struct packed {
    logic cmd_error;
    logic exec_error;
    logic query_error;
    logic opc_cmd;
    logic ops_done;
  } sesr_std_src_t;

  // Request state: idle, raised until serial poll, or polled
  typedef enum logic [1:0] {
    SESR_REQ_IDLE   = 2'b00,
    SESR_REQ_RAISED = 2'b01,
    SESR_REQ_POLLED = 2'b11
  } sesr_req_state_t;

endpackage

// [sesr_status.sv]
// Status event registers, status byte and service request logic
`timescale 1ns/1ps
module sesr_status
  import sesr_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire sesr_req_t     req_i,
  output logic [7:0]         rdata_o,
  output logic               rvalid_o,
  input  wire sesr_std_src_t std_src_i,
  input  wire sesr_op_src_t  op_src_i,
  input  wire logic [7:0]    op_condition_i,
  input  wire logic          msg_avail_i,
  input  wire logic          clear_status_i,
  input  wire logic          serial_poll_i,
  output logic [7:0]         poll_byte_o,
  output logic               srq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]      std_event_latch;
  logic [7:0]      std_event_mask;
  logic [7:0]      op_event_latch;
  logic [7:0]      op_event_mask;
  logic [7:0]      service_req_mask;
  logic            opc_armed;
  logic            power_seen;
  logic            mss_q;
  sesr_req_state_t req_state;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  wire rd_std    = req_i.valid & ~req_i.write & (req_i.reg_sel == SESR_CMD_STD_LATCH);
  wire rd_op     = req_i.valid & ~req_i.write & (req_i.reg_sel == SESR_CMD_OP_LATCH);
  wire wr_std_m  = req_i.valid & req_i.write & (req_i.reg_sel == SESR_CMD_STD_MASK);
  wire wr_op_m   = req_i.valid & req_i.write & (req_i.reg_sel == SESR_CMD_OP_MASK);
  wire wr_srv_m  = req_i.valid & req_i.write & (req_i.reg_sel == SESR_CMD_SRV_MASK);
  wire clr_std   = rd_std | clear_status_i;
  wire clr_op    = rd_op | clear_status_i;

  ////////////////////////////////////////////////////////////////////////
  // Event pulses mapped to bit positions
  logic [7:0] std_set;
  logic [7:0] op_set;
  always_comb begin
    std_set = 8'h00;
    std_set[SE_PON_BIT] = ~power_seen;
    std_set[SE_CME_BIT] = std_src_i.cmd_error;
    std_set[SE_EXE_BIT] = std_src_i.exec_error;
    std_set[SE_QYE_BIT] = std_src_i.query_error;
    std_set[SE_OPC_BIT] = opc_armed & std_src_i.ops_done;
    op_set = {op_src_i.comm_lost, op_src_i.cal_bad, 1'b0,
              op_src_i.fresh_sample_flag,
              op_src_i.loop1_slope_finished,
              op_src_i.loop2_slope_finished,
              op_src_i.input_a_overrange,
              op_src_i.input_b_overrange};
  end

  // Set wins over clear so a coinciding event is kept
  wire [7:0] next_std_latch = (std_event_latch & {8{~clr_std}}) | std_set;
  wire [7:0] next_op_latch  = (op_event_latch & {8{~clr_op}}) | op_set;

  ////////////////////////////////////////////////////////////////////////
  // Event latches; power-on flag set once after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      std_event_latch <= SESR_LATCH_RESET;
      op_event_latch  <= SESR_LATCH_RESET;
      power_seen      <= 1'b0;
    end else begin
      std_event_latch <= next_std_latch;
      op_event_latch  <= next_op_latch;
      power_seen      <= 1'b1;
    end
  end

  // Operation complete armed by command, disarmed when done
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      opc_armed <= 1'b0;
    end else if (std_src_i.opc_cmd) begin
      opc_armed <= 1'b1;
    end else if (std_src_i.ops_done) begin
      opc_armed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mask registers, written whole; writing zero clears
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      std_event_mask   <= SESR_MASK_RESET;
      op_event_mask    <= SESR_MASK_RESET;
      service_req_mask <= SESR_MASK_RESET;
    end else begin
      if (wr_std_m) std_event_mask <= req_i.wdata;
      if (wr_op_m)  op_event_mask <= req_i.wdata;
      if (wr_srv_m) service_req_mask <= req_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary bits are pure logic, never latched
  wire std_summary = |(std_event_latch & std_event_mask);
  wire op_summary_flag = |(op_event_latch & op_event_mask);
  logic [7:0] sum_bits;
  always_comb begin
    sum_bits = 8'h00;
    sum_bits[SB_OSB_BIT] = op_summary_flag;
    sum_bits[SB_ESB_BIT] = std_summary;
    sum_bits[SB_MAV_BIT] = msg_avail_i;
  end
  // Bit 6 of the mask is ignored; bit 6 is never its own source
  wire mss = |(sum_bits & service_req_mask);
  wire [7:0] summary_byte = sum_bits | ({7'h00, mss} << SB_RQS_BIT);

  ////////////////////////////////////////////////////////////////////////
  // Request on rising master summary; poll clears the request only
  wire mss_rise = mss & ~mss_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mss_q     <= 1'b0;
      req_state <= SESR_REQ_IDLE;
    end else begin
      mss_q <= mss;
      case (req_state)
        SESR_REQ_IDLE:   if (mss_rise) req_state <= SESR_REQ_RAISED;
        SESR_REQ_RAISED: if (serial_poll_i) req_state <= SESR_REQ_POLLED;
        SESR_REQ_POLLED: if (mss_rise) req_state <= SESR_REQ_RAISED;
                         else if (!mss) req_state <= SESR_REQ_IDLE;
        default:         req_state <= SESR_REQ_IDLE;
      endcase
    end
  end
  // Request stays off after a poll until master summary falls and rises again
  assign srq_o = (req_state == SESR_REQ_RAISED);

  ////////////////////////////////////////////////////////////////////////
  // Poll byte shows request view of bit 6
  logic [7:0] poll_byte;
  always_comb begin
    poll_byte = sum_bits;
    poll_byte[SB_RQS_BIT] = srq_o;
  end

  ////////////////////////////////////////////////////////////////////////
  // Query read mux; value is the plain binary-weighted byte
  logic [7:0] rd_mux;
  always_comb begin
    case (req_i.reg_sel)
      SESR_CMD_STD_MASK:  rd_mux = std_event_mask;
      SESR_CMD_STD_LATCH: rd_mux = std_event_latch;
      SESR_CMD_OP_MASK:   rd_mux = op_event_mask;
      SESR_CMD_OP_LATCH:  rd_mux = op_event_latch;
      SESR_CMD_OP_COND:   rd_mux = op_condition_i;
      SESR_CMD_SUMMARY:   rd_mux = summary_byte;
      SESR_CMD_SRV_MASK:  rd_mux = service_req_mask;
      default:            rd_mux = 8'h00;
    endcase
  end

  // Read data registered one cycle after the query
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o     <= 8'h00;
      rvalid_o    <= 1'b0;
      poll_byte_o <= 8'h00;
    end else begin
      rvalid_o <= req_i.valid & ~req_i.write;
      if (req_i.valid & ~req_i.write) rdata_o <= rd_mux;
      if (serial_poll_i) poll_byte_o <= poll_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  std_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_std && !(|std_set) |=> std_event_latch == 8'h00)
    else $error("standard latch not cleared by query");
  op_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    op_src_i.fresh_sample_flag |=> op_event_latch[4])
    else $error("fresh sample event lost");
  set_wins_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clear_status_i && std_src_i.cmd_error |=> std_event_latch[SE_CME_BIT])
    else $error("event lost on coincident clear");
  cls_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    clear_status_i && !(|op_set) |=> op_event_latch == 8'h00)
    else $error("clear status left op events");
  srq_rise_a: assert property (@(posedge clk_i) disable iff (reset_i)
    mss && !$past(mss) && req_state != SESR_REQ_RAISED |=> srq_o)
    else $error("no request on rising summary");
  poll_clear_a: assert property (@(posedge clk_i) disable iff (reset_i)
    srq_o && serial_poll_i && mss |=> !srq_o && summary_byte[SB_RQS_BIT])
    else $error("poll did not clear request only");
  no_rerequest_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !srq_o && mss && $past(mss) |=> !srq_o)
    else $error("request raised without new rise");
  mss_track_a: assert property (@(posedge clk_i) disable iff (reset_i)
    summary_byte[SB_RQS_BIT] == |(sum_bits & service_req_mask))
    else $error("master summary mismatch");
  srv_mask_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_srv_m |=> service_req_mask == $past(req_i.wdata))
    else $error("service mask write lost");
  opc_a: assert property (@(posedge clk_i) disable iff (reset_i)
    opc_armed && std_src_i.ops_done |=> std_event_latch[SE_OPC_BIT])
    else $error("operation complete not set");

  cov_srq_c:  cover property (@(posedge clk_i) disable iff (reset_i) mss_rise ##1 srq_o);
  cov_poll_c: cover property (@(posedge clk_i) disable iff (reset_i) srq_o && serial_poll_i);
  cov_clr_c:  cover property (@(posedge clk_i) disable iff (reset_i) clr_std && |std_set);
  cov_rearm_c: cover property (@(posedge clk_i) disable iff (reset_i)
    req_state == SESR_REQ_POLLED ##1 req_state == SESR_REQ_IDLE);

endmodule // sesr_status

// [sesr_status_bench.sv]
// Self-checking bench for the status event and service request block
`timescale 1ns/1ps
module sesr_status_bench;
  import sesr_pkg::*;
  logic          clk_i, reset_i, msg_avail_i, clear_status_i, serial_poll_i;
  logic          srq_o, rvalid_o, en;
  sesr_req_t     req_i;
  sesr_std_src_t std_src_i;
  sesr_op_src_t  op_src_i;
  logic [7:0]    op_condition_i, rdata_o, poll_byte_o, seen, m, v;
  logic [3:0]    dly;
  int            polls, num_errors, cmp_count, seed, i;

  sesr_status i_sesr_status (.clk_i, .reset_i, .req_i, .rdata_o, .rvalid_o, .std_src_i,
    .op_src_i, .op_condition_i, .msg_avail_i, .clear_status_i, .serial_poll_i,
    .poll_byte_o, .srq_o);
  sesr_ctrl_model i_sesr_ctrl_model (.clk_i, .srq_i(srq_o), .en_i(en), .delay_i(dly),
    .poll_byte_i(poll_byte_o), .serial_poll_o(serial_poll_i), .seen_o(seen),
    .polls_o(polls));

  ////////////////////////////////////////
  // Clock, watchdog and verdict
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  task summarize();
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
    end
  endtask

  // Bus tasks drive at the falling edge; valid drops one cycle later
  task cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task wr(input sesr_cmd_t s, input logic [7:0] d);
    @(negedge clk_i);
    req_i <= {2'b11, s, d};
    @(negedge clk_i);
    req_i <= '0;
  endtask
  task rd(input sesr_cmd_t s, input logic [7:0] e);
    @(negedge clk_i);
    req_i <= {2'b10, s, 8'h00};
    @(negedge clk_i);
    req_i <= '0;
    chk({7'h00, rvalid_o}, 8'h01);
    chk(rdata_o, e);
  endtask
  task pulse(input logic c, input logic [4:0] s, input logic [6:0] o);
    @(negedge clk_i);
    clear_status_i <= c;
    std_src_i <= s;
    op_src_i <= o;
    @(negedge clk_i);
    clear_status_i <= 1'b0;
    std_src_i <= '0;
    op_src_i <= '0;
  endtask

  // Expected values; operation bit 5 is unused
  function logic [7:0] opmap(input logic [6:0] x);
    return {x[6:5], 1'b0, x[4:0]};
  endfunction
  function logic [7:0] stb(input logic [7:0] se, sm, oe, om, sr, input logic mav);
    logic [7:0] b;
    b = {|(oe & om), 1'b0, |(se & sm), mav, 4'h0};
    b[6] = |(b & sr & 8'hb0);
    return b;
  endfunction

  ////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h96b6;
    {req_i, std_src_i, op_src_i, op_condition_i} = '0;
    {msg_avail_i, clear_status_i, en, dly, num_errors, cmp_count} = '0;
    reset_i = 1'b1;
    cyc(20);
    reset_i <= 1'b0;
    cyc(2);
    rd(SESR_CMD_STD_LATCH, 8'h80);
    rd(SESR_CMD_STD_LATCH, 8'h00);
    pulse(0, 5'b10000, 0); rd(SESR_CMD_STD_LATCH, 8'h20);
    pulse(0, 5'b01000, 0); rd(SESR_CMD_STD_LATCH, 8'h10);
    pulse(0, 5'b00100, 0); rd(SESR_CMD_STD_LATCH, 8'h04);
    pulse(0, 5'b00001, 0); rd(SESR_CMD_STD_LATCH, 8'h00);
    pulse(0, 5'b00010, 0); pulse(0, 5'b00001, 0); rd(SESR_CMD_STD_LATCH, 8'h01);
    // Random operation events, condition values and mask traffic
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      pulse(0, 0, v[6:0]); rd(SESR_CMD_OP_LATCH, opmap(v[6:0]));
      op_condition_i <= ~v;
      rd(SESR_CMD_OP_COND, ~v); rd(SESR_CMD_OP_LATCH, 8'h00);
      m = $random(seed);
      wr(SESR_CMD_STD_MASK, m); rd(SESR_CMD_STD_MASK, m);
      wr(SESR_CMD_OP_MASK, ~m); rd(SESR_CMD_OP_MASK, ~m);
      wr(SESR_CMD_SRV_MASK, v); rd(SESR_CMD_SRV_MASK, v); rd(SESR_CMD_SRV_MASK, v);
    end
    // Mid-run reset drops any request left over from the random masks
    reset_i <= 1'b1;
    cyc(2);
    reset_i <= 1'b0;
    cyc(2);
    chk({7'h00, srq_o}, 8'h00);
    rd(SESR_CMD_STD_LATCH, 8'h80);
    // Command error raises a request; host held off first
    wr(SESR_CMD_SRV_MASK, 8'h00); rd(SESR_CMD_SRV_MASK, 8'h00);
    wr(SESR_CMD_STD_MASK, 8'h20); wr(SESR_CMD_OP_MASK, 8'h00); wr(SESR_CMD_SRV_MASK, 8'h20);
    pulse(0, 5'b10000, 0); cyc(2); chk({7'h00, srq_o}, 8'h01);
    rd(SESR_CMD_SUMMARY, stb(8'h20, 8'h20, 0, 0, 8'h20, 0));
    dly = $random(seed);
    en = 1'b1;
    cyc(20); chk(8'(polls), 8'h01); chk(seen, 8'h60); chk({7'h00, srq_o}, 8'h00);
    rd(SESR_CMD_SUMMARY, 8'h60);
    pulse(0, 5'b10000, 0); cyc(3); chk({7'h00, srq_o}, 8'h00);
    msg_avail_i = 1'b1;
    rd(SESR_CMD_SUMMARY, stb(8'h20, 8'h20, 0, 0, 8'h20, 1));
    rd(SESR_CMD_STD_LATCH, 8'h20); rd(SESR_CMD_SUMMARY, 8'h10);
    wr(SESR_CMD_SRV_MASK, 8'h10); cyc(20); chk(8'(polls), 8'h02); chk(seen, 8'h50);
    msg_avail_i = 1'b0;
    wr(SESR_CMD_OP_MASK, 8'h80); wr(SESR_CMD_SRV_MASK, 8'h80);
    pulse(0, 0, 7'h40); rd(SESR_CMD_SUMMARY, 8'hc0);
    cyc(20); chk(8'(polls), 8'h03);
    // Clear-status meets a new event in the same cycle
    pulse(0, 0, 7'h7f); pulse(1, 5'b10000, 0);
    rd(SESR_CMD_STD_LATCH, 8'h20); rd(SESR_CMD_OP_LATCH, 8'h00);
    rd(SESR_CMD_SUMMARY, 8'h00); rd(SESR_CMD_NONE, 8'h00);
    summarize();
  end
endmodule // sesr_status_bench
